// File: common/pie_pkg.sv
// Purpose: shared constants and carriers for the peripheral irq enables
// Assumes: 8-bit register port, byte addresses, one clock
// Notes: offsets are spaced by four so each register owns a word slot
package pie_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NUM_GRP = 3;
	localparam int PC_W = 16;

	// register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_EN1 = 8'h04;
	localparam logic [7:0] OFS_EN2 = 8'h08;
	localparam logic [7:0] OFS_EN3 = 8'h0c;
	localparam logic [7:0] OFS_FL1 = 8'h10;
	localparam logic [7:0] OFS_FL2 = 8'h14;
	localparam logic [7:0] OFS_FL3 = 8'h18;

	// implemented positions of each enable / flag group
	localparam logic [7:0] IMPL_MASK1 = 8'hff;
	localparam logic [7:0] IMPL_MASK2 = 8'hf9;
	localparam logic [7:0] IMPL_MASK3 = 8'h3a;
	localparam logic [7:0] RESET_EN = 8'h00;
	localparam logic [7:0] RESET_FL = 8'h00;

	// control register fields
	localparam int CTRL_GLOBAL_BIT = 7;
	localparam int CTRL_GROUP_BIT = 6;

	// first group field positions
	localparam int TIMER1_GATE_BIT = 7;
	localparam int CONVERTER_BIT = 6;
	localparam int SERIAL_RECEIVE_BIT = 5;
	localparam int SERIAL_TRANSMIT_BIT = 4;
	localparam int SYNC_PORT_ONE_BIT = 3;
	localparam int CAPTURE_ONE_BIT = 2;
	localparam int TIMER2_MATCH_BIT = 1;
	localparam int TIMER1_OVERFLOW_BIT = 0;
	// second group field positions
	localparam int OSC_FAIL_BIT = 7;
	localparam int COMPARATOR_TWO_BIT = 6;
	localparam int COMPARATOR_ONE_BIT = 5;
	localparam int EEPROM_DONE_BIT = 4;
	localparam int BUS_COLLISION_ONE_BIT = 3;
	localparam int CAPTURE_TWO_BIT = 0;
	// third group field positions
	localparam int CAPTURE_FOUR_BIT = 5;
	localparam int CAPTURE_THREE_BIT = 4;
	localparam int TIMER6_MATCH_BIT = 3;
	localparam int TIMER4_MATCH_BIT = 1;

	localparam logic [15:0] VECTOR_ADDR = 16'h0004;
	localparam logic [15:0] RESET_VEC = 16'h0000;
	localparam logic [7:0] READ_IDLE = 8'h00;

	typedef struct packed {
		logic [7:0] grp3;
		logic [7:0] grp2;
		logic [7:0] grp1;
	} pieSrc_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wrData;
		logic wrStb;
		logic rdStb;
	} pieBusReq_type;

	typedef enum logic [1:0] {
		PIE_IDLE = 2'b00,
		PIE_PUSH = 2'b01,
		PIE_LOAD = 2'b11
	} pieAccState_type;
endpackage

// File: design/pie_enables.sv
// Purpose: peripheral interrupt enables, flags and request gating
// Assumes: sources and bus come from logic on sys_clk
// Notes: flags are sticky, cleared by writing a one to them
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module pie_enables (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire pie_pkg::pieBusReq_type busReq,
	output logic [7:0] rdData,
	input wire pie_pkg::pieSrc_type srcEvent,
	input wire logic coreAccept,
	input wire logic isrReturn,
	output logic periphReq,
	output logic irqOut,
	output logic globalEnable,
	output logic pushPc,
	output logic loadVector,
	output logic [15:0] vectorAddr
);
	logic [7:0] en_q [pie_pkg::NUM_GRP];
	logic [7:0] fl_q [pie_pkg::NUM_GRP];
	logic [7:0] src [pie_pkg::NUM_GRP];
	logic [pie_pkg::NUM_GRP-1:0] enHit;
	logic [pie_pkg::NUM_GRP-1:0] flHit;
	logic [pie_pkg::NUM_GRP-1:0] grpReq;
	logic global_q;
	logic group_q;
	logic [7:0] rdData_q;
	logic [7:0] rdData_d;
	logic [15:0] vector_q;
	logic ctrlHit;
	logic accept;
	pie_pkg::pieAccState_type state_q;
	pie_pkg::pieAccState_type state_d;

	function automatic logic [7:0] implMask(input int g);
		case (g)
			0: implMask = pie_pkg::IMPL_MASK1;
			1: implMask = pie_pkg::IMPL_MASK2;
			default: implMask = pie_pkg::IMPL_MASK3;
		endcase
	endfunction

	// one-hot select of the enable registers
	function automatic logic [2:0] enSel(input logic [7:0] a);
		enSel = {a == pie_pkg::OFS_EN3, a == pie_pkg::OFS_EN2,
			a == pie_pkg::OFS_EN1};
	endfunction

	// one-hot select of the flag registers
	function automatic logic [2:0] flSel(input logic [7:0] a);
		flSel = {a == pie_pkg::OFS_FL3, a == pie_pkg::OFS_FL2,
			a == pie_pkg::OFS_FL1};
	endfunction

	assign src[0] = srcEvent.grp1;
	assign src[1] = srcEvent.grp2;
	assign src[2] = srcEvent.grp3;
	assign enHit = enSel(busReq.addr);
	assign flHit = flSel(busReq.addr);
	assign ctrlHit = busReq.addr == pie_pkg::OFS_CTRL;

	genvar g;
	generate
		for (g = 0; g < pie_pkg::NUM_GRP; g++) begin : grp
			// enable register; unimplemented bits never store
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					en_q[g] <= pie_pkg::RESET_EN;
				end else if (clkEn && busReq.wrStb && enHit[g]) begin
					en_q[g] <= busReq.wrData & implMask(g);
				end
			end

			// sticky flags: an event in the clearing cycle is kept
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					fl_q[g] <= pie_pkg::RESET_FL;
				end else if (clkEn) begin
					fl_q[g] <= ((fl_q[g] & ~((busReq.wrStb && flHit[g]) ?
						busReq.wrData : 8'h00)) | src[g]) & implMask(g);
				end
			end

			assign grpReq[g] = |(fl_q[g] & en_q[g]);
		end
	endgenerate

	// group gate first, then global gate; flags alone never interrupt
	assign periphReq = group_q && |grpReq;
	assign irqOut = global_q && periphReq;
	assign globalEnable = global_q;
	assign accept = clkEn && state_q == pie_pkg::PIE_IDLE &&
		coreAccept && irqOut;

	// control register: global and group enables
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			group_q <= 1'b0;
		end else if (clkEn && busReq.wrStb && ctrlHit) begin
			group_q <= busReq.wrData[pie_pkg::CTRL_GROUP_BIT];
		end
	end

	// acceptance clears the global enable so the routine is not re-entered
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			global_q <= 1'b0;
		end else if (accept) begin
			global_q <= 1'b0;
		end else if (clkEn && isrReturn) begin
			global_q <= 1'b1;
		end else if (clkEn && busReq.wrStb && ctrlHit) begin
			global_q <= busReq.wrData[pie_pkg::CTRL_GLOBAL_BIT];
		end
	end

	// entry sequence: push then vector load, one step per enabled cycle
	always_comb begin
		state_d = state_q;
		case (state_q)
			pie_pkg::PIE_IDLE: begin
				if (accept) begin
					state_d = pie_pkg::PIE_PUSH;
				end
			end
			pie_pkg::PIE_PUSH: begin
				state_d = pie_pkg::PIE_LOAD;
			end
			pie_pkg::PIE_LOAD: begin
				state_d = pie_pkg::PIE_IDLE;
			end
			default: begin
				state_d = pie_pkg::PIE_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= pie_pkg::PIE_IDLE;
		end else if (clkEn) begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			vector_q <= pie_pkg::RESET_VEC;
		end else if (clkEn && state_q == pie_pkg::PIE_PUSH) begin
			vector_q <= pie_pkg::VECTOR_ADDR;
		end
	end

	assign pushPc = state_q == pie_pkg::PIE_PUSH;
	assign loadVector = state_q == pie_pkg::PIE_LOAD;
	assign vectorAddr = vector_q;

	// read mux; unmapped and unimplemented positions give zero
	always_comb begin
		rdData_d = pie_pkg::READ_IDLE;
		if (ctrlHit) begin
			rdData_d[pie_pkg::CTRL_GLOBAL_BIT] = global_q;
			rdData_d[pie_pkg::CTRL_GROUP_BIT] = group_q;
		end
		for (int i = 0; i < pie_pkg::NUM_GRP; i++) begin
			if (enHit[i]) begin
				rdData_d = en_q[i] & implMask(i);
			end
			if (flHit[i]) begin
				rdData_d = fl_q[i];
			end
		end
	end

	// data stands for the one cycle after the strobe only
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData_q <= pie_pkg::READ_IDLE;
		end else if (clkEn) begin
			rdData_q <= busReq.rdStb ? rdData_d : pie_pkg::READ_IDLE;
		end
	end
	assign rdData = rdData_q;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	sequence seqWrEn1;
		clkEn && busReq.wrStb && busReq.addr == pie_pkg::OFS_EN1;
	endsequence

	sequence seqWrEn2;
		clkEn && busReq.wrStb && busReq.addr == pie_pkg::OFS_EN2;
	endsequence

	sequence seqRdEn3;
		clkEn && busReq.rdStb && busReq.addr == pie_pkg::OFS_EN3;
	endsequence

	sequence seqAccept;
		clkEn && state_q == pie_pkg::PIE_IDLE && coreAccept && irqOut;
	endsequence

	sequence seqEntry;
		pushPc && !global_q ##1 loadVector;
	endsequence

	property pWriteStores;
		seqWrEn1 |=> en_q[0] == $past(busReq.wrData);
	endproperty

	enable_one_wr_a: assert property (pWriteStores)
		else $error("first enable register did not store the write");

	enable_two_mask_a: assert property (
		seqWrEn2 |=> en_q[1] == ($past(busReq.wrData) & 8'hf9))
		else $error("second enable register stored unimplemented bits");

	enable_three_zero_a: assert property (
		(en_q[2] & 8'hc5) == 8'h00)
		else $error("third enable register holds unimplemented bits");

	unimpl_read_zero_a: assert property (
		seqRdEn3 |=> rdData[7:6] == 2'b00 && rdData[2] == 1'b0 &&
			rdData[0] == 1'b0)
		else $error("unimplemented bits of third enable read nonzero");

	enable_two_read_a: assert property (
		clkEn && busReq.rdStb && busReq.addr == pie_pkg::OFS_EN2 |=>
			rdData == ($past(en_q[1]) & 8'hf9))
		else $error("second enable register read back wrong");

	group_gate_a: assert property (
		!group_q |-> !periphReq && !irqOut)
		else $error("peripheral request without group enable");

	reset_clear_a: assert property (@(posedge sys_clk) disable iff (1'b0)
		!rst_b |-> en_q[0] == 8'h00 && en_q[1] == 8'h00 &&
			en_q[2] == 8'h00)
		else $error("enable registers not cleared during reset");

	flag_sets_a: assert property (
		clkEn && (|srcEvent.grp1) && !group_q |=>
			(fl_q[0] & $past(srcEvent.grp1)) == $past(srcEvent.grp1))
		else $error("flag not set while enables were off");

	set_beats_clear_a: assert property (
		clkEn && busReq.wrStb && busReq.addr == pie_pkg::OFS_FL1 &&
			srcEvent.grp1[0] |=> fl_q[0][0])
		else $error("event lost in the clearing cycle");

	accept_entry_a: assert property (
		seqAccept ##1 clkEn |-> seqEntry)
		else $error("accept did not push and load the vector");

	vector_value_a: assert property (
		loadVector |-> vectorAddr == 16'h0004)
		else $error("vector address wrong at load");

	request_cause_a: assert property (
		periphReq |-> (|(fl_q[0] & en_q[0])) || (|(fl_q[1] & en_q[1])) ||
			(|(fl_q[2] & en_q[2])))
		else $error("peripheral request without enabled flag");

	request_rise_a: assert property (
		group_q && global_q && (|(fl_q[2] & en_q[2])) |-> irqOut)
		else $error("enabled flag did not raise the interrupt");

	read_one_cycle_a: assert property (
		clkEn && !busReq.rdStb |=> rdData == 8'h00)
		else $error("read data stood beyond its cycle");
endmodule

// File: dv/test_peripheral_interrupt_enables.sv
// Purpose: self-checking bench for the peripheral irq enables
// Assumes: register port offsets and masks from pie_pkg
// Notes: reads are checked one cycle later by a monitor from a queue
`timescale 1ns/10ps
module test_peripheral_interrupt_enables;
	logic sys_clk, rst_b, clkEn, coreAccept, isrReturn;
	pie_pkg::pieBusReq_type busReq;
	pie_pkg::pieSrc_type srcEvent;
	logic [7:0] rdData;
	logic periphReq, irqOut, globalEnable, pushPc, loadVector;
	logic [15:0] vectorAddr;
	logic [7:0] expQ[$];
	logic rdPend = 1'b0;
	logic [31:0] seed;
	int bad_count, total_checks;
	logic [7:0] ofs[3];
	logic [7:0] msk[3];

	pie_enables dut (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.busReq(busReq),
		.rdData(rdData),
		.srcEvent(srcEvent),
		.coreAccept(coreAccept),
		.isrReturn(isrReturn),
		.periphReq(periphReq),
		.irqOut(irqOut),
		.globalEnable(globalEnable),
		.pushPc(pushPc),
		.loadVector(loadVector),
		.vectorAddr(vectorAddr)
	);

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		busReq <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk);
		busReq <= '{a, d, 1'b0, 1'b0};
	endtask

	// expectation is queued before the strobe so the monitor finds it
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		busReq <= '{a, 8'h00, 1'b0, 1'b1};
		expQ.push_back(exp);
		@(posedge sys_clk);
		busReq <= '{a, 8'h00, 1'b0, 1'b0};
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// read data stand only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (rdPend) begin
			check(16'(rdData), 16'(expQ.pop_front()));
		end
		rdPend = rst_b && clkEn && busReq.rdStb;
	end

	initial begin
		repeat (3000) @(posedge sys_clk);
		bad_count++;
		report_and_stop();
	end

	initial begin
		rst_b = 1'b0;
		clkEn = 1'b1;
		coreAccept = 1'b0;
		isrReturn = 1'b0;
		busReq = '0;
		srcEvent = '0;
		seed = 32'd9496;
		bad_count = 0;
		total_checks = 0;
		ofs = '{pie_pkg::OFS_EN1, pie_pkg::OFS_EN2, pie_pkg::OFS_EN3};
		msk = '{pie_pkg::IMPL_MASK1, pie_pkg::IMPL_MASK2, pie_pkg::IMPL_MASK3};
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rd(ofs[i], pie_pkg::RESET_EN);
			wr(ofs[i], 8'hff);
			rd(ofs[i], msk[i]);
			repeat (4) begin
				seed = xorshift(seed);
				wr(ofs[i], seed[7:0]);
				rd(ofs[i], seed[7:0] & msk[i]);
			end
			wr(ofs[i], 8'h00);
		end
		rd(8'h20, 8'h00);
		$display("test registers done");
		// flags must set with the group and peripheral enables off
		wr(pie_pkg::OFS_CTRL, 8'h80);
		@(posedge sys_clk);
		srcEvent <= {8'h3a, 8'hf9, 8'hff};
		@(posedge sys_clk);
		srcEvent <= '0;
		rd(pie_pkg::OFS_FL1, 8'hff);
		rd(pie_pkg::OFS_FL2, 8'hf9);
		rd(pie_pkg::OFS_FL3, 8'h3a);
		check(16'(irqOut), 16'h0000);
		wr(pie_pkg::OFS_EN1, 8'h01);
		@(negedge sys_clk);
		check(16'({periphReq, irqOut}), 16'h0000);
		wr(pie_pkg::OFS_CTRL, 8'hc0);
		@(negedge sys_clk);
		check(16'({periphReq, irqOut}), 16'h0003);
		rd(pie_pkg::OFS_CTRL, 8'hc0);
		$display("test gating done");
		@(posedge sys_clk);
		coreAccept <= 1'b1;
		@(posedge sys_clk);
		coreAccept <= 1'b0;
		@(negedge sys_clk);
		check(16'({pushPc, globalEnable, irqOut}), 16'h0004);
		@(negedge sys_clk);
		check(16'({pushPc, loadVector}), 16'h0001);
		check(vectorAddr, pie_pkg::VECTOR_ADDR);
		@(posedge sys_clk);
		isrReturn <= 1'b1;
		@(posedge sys_clk);
		isrReturn <= 1'b0;
		@(negedge sys_clk);
		check(16'({globalEnable, irqOut, loadVector}), 16'h0006);
		// clear and a fresh event in one cycle: the event must survive
		@(posedge sys_clk);
		busReq <= '{pie_pkg::OFS_FL1, 8'hff, 1'b1, 1'b0};
		srcEvent <= '{8'h00, 8'h00, 8'h01};
		@(posedge sys_clk);
		busReq <= '{pie_pkg::OFS_FL1, 8'hff, 1'b0, 1'b0};
		srcEvent <= '0;
		rd(pie_pkg::OFS_FL1, 8'h01);
		wr(pie_pkg::OFS_FL1, 8'hff);
		@(negedge sys_clk);
		check(16'(periphReq), 16'h0000);
		$display("test accept done");
		// a write while the clock enable is low must be lost
		@(posedge sys_clk);
		clkEn <= 1'b0;
		wr(pie_pkg::OFS_EN2, 8'hff);
		clkEn <= 1'b1;
		rd(pie_pkg::OFS_EN2, 8'h00);
		wr(pie_pkg::OFS_EN3, 8'hff);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rd(ofs[i], pie_pkg::RESET_EN);
		end
		check(vectorAddr, pie_pkg::RESET_VEC);
		repeat (2) @(posedge sys_clk);
		$display("test reset done");
		report_and_stop();
	end
endmodule
